// *** logic/uisc_pkg.sv ***
// Register map, field layout and carrier types of the serial port interrupt slice
package uisc_pkg;

   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int NSRC = 7;

   localparam logic [11:0] OFF_MASK = 12'h038;
   localparam logic [11:0] OFF_RAW = 12'h03c;
   localparam logic [11:0] OFF_MIS = 12'h040;
   localparam logic [11:0] OFF_ICR = 12'h044;
   localparam logic [11:0] OFF_ID4 = 12'hfd0;
   localparam logic [11:0] OFF_ID5 = 12'hfd4;

   // Source bit positions inside every status, mask and clear word
   localparam int POS_OVERRUN = 10;
   localparam int POS_BREAK = 9;
   localparam int POS_PARITY = 8;
   localparam int POS_FRAMING = 7;
   localparam int POS_RX_TIMEOUT = 6;
   localparam int POS_TRANSMIT = 5;
   localparam int POS_RECEIVE = 4;
   localparam int FLD_MSB = POS_OVERRUN;
   localparam int FLD_LSB = POS_RECEIVE;

   localparam int ID_MSB = 7;
   localparam logic [3:0] RAW_LOW_RSVD = 4'hf;

   localparam logic [6:0] RST_FLAGS = 7'h00;
   localparam logic [31:0] RST_RDATA = 32'h0000_0000;

   // One bit per source, packed in register order from bit 10 down to bit 4
   typedef struct packed {
      logic overrun;
      logic brk;
      logic parity;
      logic framing;
      logic rx_timeout;
      logic transmit;
      logic receive;
   } uisc_flags_t;

   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } uisc_bus_req_t;

endpackage : uisc_pkg

// *** logic/uisc_flag_bits.sv ***
// Sticky status bits: pulses set them, a per-bit clear mask drops any of them at once
`timescale 1ns/1ps
module uisc_flag_bits #(
   parameter int W = 7
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Set and clear strobes, one bit per source
   input wire logic [W-1:0] i_set,
   input wire logic [W-1:0] i_clr,
   // Held state
   output logic [W-1:0] o_flags_q
);

   logic [W-1:0] flags_d;

   // A set in the same cycle as its clear is kept
   always_comb begin
      flags_d = (o_flags_q & ~i_clr) | i_set;
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_flags_q <= '0;
      end else begin
         o_flags_q <= flags_d;
      end
   end

endmodule : uisc_flag_bits

// *** logic/uisc_irq_status.sv ***
// Interrupt status, mask, clear and identification registers of the serial port
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
// How it works
// - Masked status register reads current masked state per source; zero after reset.
// - Writes to the masked status register are ignored; no state changes.
// - Masked bits: overrun 10, break 9, parity 8, framing 7, timeout 6, tx 5, rx 4.
// - Masked bit equals raw bit AND mask bit; only masked sources reach the controller.
// - Writing one to a clear bit drops raw status, hence masked status too.
// - Writing zero to a clear bit leaves that source's state alone.
// - Clear bits use the same positions as status bits, 10 down to 4.
// - Reserved bits read undefined; software keeps them; writes to them do nothing.
// - Two identification registers hold constant read-only values in bits 7:0.
// - First identification register gives ident bits 7:0, second gives bits 15:8.
module uisc_irq_status #(
   // Arbitrary identification values
   parameter logic [7:0] IDENT_LOW = 8'h5a,
   parameter logic [7:0] IDENT_NEXT = 8'ha5
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Register port
   input wire logic [11:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   // Event pulses from the serial engine
   input wire uisc_pkg::uisc_flags_t i_src_evt,
   // Toward the system interrupt controller
   output uisc_pkg::uisc_flags_t o_masked,
   output logic o_irq
);

   uisc_pkg::uisc_bus_req_t req;
   uisc_pkg::uisc_flags_t raw_q;
   uisc_pkg::uisc_flags_t mask_q;
   uisc_pkg::uisc_flags_t mask_d;
   uisc_pkg::uisc_flags_t mis;
   uisc_pkg::uisc_flags_t clr;
   uisc_pkg::uisc_flags_t wr_field;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   uisc_pkg::uisc_flags_t masked_q;
   logic irq_q;

   // Place a seven-source field into a bus word, every other bit zero
   function automatic logic [31:0] place_flags(input uisc_pkg::uisc_flags_t f);
      logic [31:0] w;
      w = '0;
      w[uisc_pkg::FLD_MSB:uisc_pkg::FLD_LSB] = f;
      return w;
   endfunction : place_flags

   // Pull the seven-source field out of a bus word
   function automatic uisc_pkg::uisc_flags_t take_flags(input logic [31:0] w);
      return uisc_pkg::uisc_flags_t'(w[uisc_pkg::FLD_MSB:uisc_pkg::FLD_LSB]);
   endfunction : take_flags

   function automatic logic [31:0] place_ident(input logic [7:0] b);
      logic [31:0] w;
      w = '0;
      w[uisc_pkg::ID_MSB:0] = b;
      return w;
   endfunction : place_ident

   always_comb begin
      req.addr = i_addr;
      req.wdata = i_wdata;
      req.wr = i_wr;
      req.rd = i_rd;
   end

   always_comb begin
      wr_field = take_flags(req.wdata);
   end

   // Only set clear bits act; zeros and reserved bits are dropped
   always_comb begin
      clr = '0;
      if (req.wr && req.addr == uisc_pkg::OFF_ICR) begin
         clr = wr_field;
      end
   end

   uisc_flag_bits #(
      .W(uisc_pkg::NSRC)
   ) u_raw (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_set(i_src_evt),
      .i_clr(clr),
      .o_flags_q(raw_q)
   );

   // Mask register
   always_comb begin
      mask_d = mask_q;
      if (req.wr && req.addr == uisc_pkg::OFF_MASK) begin
         mask_d = wr_field;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         mask_q <= uisc_pkg::RST_FLAGS;
      end else begin
         mask_q <= mask_d;
      end
   end

   always_comb begin
      mis = raw_q & mask_q;
   end

   // Read decode; writes to status and identification words fall through here
   always_comb begin
      rdata_d = uisc_pkg::RST_RDATA;
      if (req.rd) begin
         case (req.addr)
            uisc_pkg::OFF_MASK: rdata_d = place_flags(mask_q);
            uisc_pkg::OFF_RAW: begin
               rdata_d = place_flags(raw_q);
               rdata_d[3:0] = uisc_pkg::RAW_LOW_RSVD;
            end
            uisc_pkg::OFF_MIS: rdata_d = place_flags(mis);
            uisc_pkg::OFF_ID4: rdata_d = place_ident(IDENT_LOW);
            uisc_pkg::OFF_ID5: rdata_d = place_ident(IDENT_NEXT);
            default: rdata_d = uisc_pkg::RST_RDATA;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         rdata_q <= uisc_pkg::RST_RDATA;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // Masked lines and the summary interrupt, one cycle behind status
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         masked_q <= uisc_pkg::RST_FLAGS;
         irq_q <= 1'b0;
      end else begin
         masked_q <= mis;
         irq_q <= |mis;
      end
   end

   always_comb begin
      o_rdata = rdata_q;
      o_masked = masked_q;
      o_irq = irq_q;
   end

   a_mis_read_value: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_rd && i_addr == uisc_pkg::OFF_MIS) |=>
      (o_rdata[uisc_pkg::FLD_MSB:uisc_pkg::FLD_LSB] == ($past(raw_q) & $past(mask_q))))
      else $error("masked status read wrong");

   a_mis_field_pos: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_rd && i_addr == uisc_pkg::OFF_MIS) |=>
      (o_rdata[uisc_pkg::POS_OVERRUN] == ($past(raw_q.overrun) && $past(mask_q.overrun))
       && o_rdata[uisc_pkg::POS_RECEIVE] == ($past(raw_q.receive) && $past(mask_q.receive))
       && o_rdata[31:11] == 21'h0 && o_rdata[3:0] == 4'h0))
      else $error("masked field placement wrong");

   // One check per source for the masked word layout
   a_mis_overrun_pos: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_rd && i_addr == uisc_pkg::OFF_MIS) |=>
      (o_rdata[uisc_pkg::POS_OVERRUN] == ($past(raw_q.overrun) && $past(mask_q.overrun))))
      else $error("overrun masked bit misplaced");

   a_mis_brk_pos: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_rd && i_addr == uisc_pkg::OFF_MIS) |=>
      (o_rdata[uisc_pkg::POS_BREAK] == ($past(raw_q.brk) && $past(mask_q.brk))))
      else $error("break masked bit misplaced");

   a_mis_parity_pos: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_rd && i_addr == uisc_pkg::OFF_MIS) |=>
      (o_rdata[uisc_pkg::POS_PARITY] == ($past(raw_q.parity) && $past(mask_q.parity))))
      else $error("parity masked bit misplaced");

   a_mis_framing_pos: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_rd && i_addr == uisc_pkg::OFF_MIS) |=>
      (o_rdata[uisc_pkg::POS_FRAMING] == ($past(raw_q.framing) && $past(mask_q.framing))))
      else $error("framing masked bit misplaced");

   a_mis_timeout_pos: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_rd && i_addr == uisc_pkg::OFF_MIS) |=>
      (o_rdata[uisc_pkg::POS_RX_TIMEOUT]
       == ($past(raw_q.rx_timeout) && $past(mask_q.rx_timeout))))
      else $error("time-out masked bit misplaced");

   a_mis_transmit_pos: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_rd && i_addr == uisc_pkg::OFF_MIS) |=>
      (o_rdata[uisc_pkg::POS_TRANSMIT] == ($past(raw_q.transmit) && $past(mask_q.transmit))))
      else $error("transmit masked bit misplaced");

   a_mis_receive_pos: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_rd && i_addr == uisc_pkg::OFF_MIS) |=>
      (o_rdata[uisc_pkg::POS_RECEIVE] == ($past(raw_q.receive) && $past(mask_q.receive))))
      else $error("receive masked bit misplaced");

   a_mis_write_ignored: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_wr && i_addr == uisc_pkg::OFF_MIS && i_src_evt == 7'h00) |=>
      ($stable(raw_q) && $stable(mask_q)))
      else $error("write to masked status changed state");

   a_clear_one: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_wr && i_addr == uisc_pkg::OFF_ICR) |=>
      ((raw_q & $past(i_wdata[uisc_pkg::FLD_MSB:uisc_pkg::FLD_LSB])
        & ~$past(i_src_evt)) == 7'h00))
      else $error("clear by one failed");

   a_clear_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_wr && i_addr == uisc_pkg::OFF_ICR) |=>
      (($past(raw_q) & ~$past(i_wdata[uisc_pkg::FLD_MSB:uisc_pkg::FLD_LSB])
        & ~raw_q) == 7'h00))
      else $error("clear by zero altered state");

   // A one in a clear bit drops exactly its own source
   a_clr_overrun_one: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_wr && i_addr == uisc_pkg::OFF_ICR && i_wdata[uisc_pkg::POS_OVERRUN]
       && !i_src_evt.overrun) |=> !raw_q.overrun)
      else $error("overrun not cleared by a one");

   a_clr_brk_one: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_wr && i_addr == uisc_pkg::OFF_ICR && i_wdata[uisc_pkg::POS_BREAK]
       && !i_src_evt.brk) |=> !raw_q.brk)
      else $error("break not cleared by a one");

   a_clr_parity_one: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_wr && i_addr == uisc_pkg::OFF_ICR && i_wdata[uisc_pkg::POS_PARITY]
       && !i_src_evt.parity) |=> !raw_q.parity)
      else $error("parity not cleared by a one");

   a_clr_framing_one: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_wr && i_addr == uisc_pkg::OFF_ICR && i_wdata[uisc_pkg::POS_FRAMING]
       && !i_src_evt.framing) |=> !raw_q.framing)
      else $error("framing not cleared by a one");

   a_clr_timeout_one: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_wr && i_addr == uisc_pkg::OFF_ICR && i_wdata[uisc_pkg::POS_RX_TIMEOUT]
       && !i_src_evt.rx_timeout) |=> !raw_q.rx_timeout)
      else $error("time-out not cleared by a one");

   a_clr_transmit_one: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_wr && i_addr == uisc_pkg::OFF_ICR && i_wdata[uisc_pkg::POS_TRANSMIT]
       && !i_src_evt.transmit) |=> !raw_q.transmit)
      else $error("transmit not cleared by a one");

   a_clr_receive_one: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_wr && i_addr == uisc_pkg::OFF_ICR && i_wdata[uisc_pkg::POS_RECEIVE]
       && !i_src_evt.receive) |=> !raw_q.receive)
      else $error("receive not cleared by a one");

   // A zero in a clear bit keeps its source set
   a_clr_overrun_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_wr && i_addr == uisc_pkg::OFF_ICR && !i_wdata[uisc_pkg::POS_OVERRUN]
       && raw_q.overrun) |=> raw_q.overrun)
      else $error("overrun dropped by a zero");

   a_clr_brk_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_wr && i_addr == uisc_pkg::OFF_ICR && !i_wdata[uisc_pkg::POS_BREAK]
       && raw_q.brk) |=> raw_q.brk)
      else $error("break dropped by a zero");

   a_clr_parity_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_wr && i_addr == uisc_pkg::OFF_ICR && !i_wdata[uisc_pkg::POS_PARITY]
       && raw_q.parity) |=> raw_q.parity)
      else $error("parity dropped by a zero");

   a_clr_framing_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_wr && i_addr == uisc_pkg::OFF_ICR && !i_wdata[uisc_pkg::POS_FRAMING]
       && raw_q.framing) |=> raw_q.framing)
      else $error("framing dropped by a zero");

   a_clr_timeout_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_wr && i_addr == uisc_pkg::OFF_ICR && !i_wdata[uisc_pkg::POS_RX_TIMEOUT]
       && raw_q.rx_timeout) |=> raw_q.rx_timeout)
      else $error("time-out dropped by a zero");

   a_clr_transmit_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_wr && i_addr == uisc_pkg::OFF_ICR && !i_wdata[uisc_pkg::POS_TRANSMIT]
       && raw_q.transmit) |=> raw_q.transmit)
      else $error("transmit dropped by a zero");

   a_clr_receive_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_wr && i_addr == uisc_pkg::OFF_ICR && !i_wdata[uisc_pkg::POS_RECEIVE]
       && raw_q.receive) |=> raw_q.receive)
      else $error("receive dropped by a zero");

   a_set_wins_clear: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_src_evt != 7'h00) |=> ((raw_q & $past(i_src_evt)) == $past(i_src_evt)))
      else $error("event lost against clear");

   a_masked_follow: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      1'b1 |=> (o_masked == ($past(raw_q) & $past(mask_q))
       && o_irq == (($past(raw_q) & $past(mask_q)) != 7'h00)))
      else $error("masked output or interrupt wrong");

   a_ident_read: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_rd && i_addr == uisc_pkg::OFF_ID5) |=> o_rdata == {24'h0, IDENT_NEXT})
      else $error("ident word wrong");

   a_ident_low_read: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_rd && i_addr == uisc_pkg::OFF_ID4) |=> o_rdata == {24'h0, IDENT_LOW})
      else $error("low ident word wrong");

   a_ident_write_quiet: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_wr && (i_addr == uisc_pkg::OFF_ID4 || i_addr == uisc_pkg::OFF_ID5)
       && i_src_evt == 7'h00) |=> ($stable(raw_q) && $stable(mask_q) && o_rdata == 32'h0))
      else $error("ident write had an effect");

   a_reset_clean: assert property (@(posedge i_clk)
      i_sys_rst |=> (raw_q == '0 && mask_q == '0 && o_irq == 1'b0 && o_rdata == 32'h0))
      else $error("state not zero after reset");

   a_mask_write_only: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !(i_wr && i_addr == uisc_pkg::OFF_MASK) |=> $stable(mask_q))
      else $error("mask changed without a mask write");

   a_raw_only_events: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      1'b1 |=> ((raw_q & ~$past(raw_q) & ~$past(i_src_evt)) == 7'h00))
      else $error("status bit set without an event");

   a_raw_read_back: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_rd && i_addr == uisc_pkg::OFF_RAW) |=>
      (o_rdata == {21'h0, $past(raw_q), uisc_pkg::RAW_LOW_RSVD}))
      else $error("raw status read wrong");

   a_mask_read_back: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_rd && i_addr == uisc_pkg::OFF_MASK) |=>
      (o_rdata == {21'h0, $past(mask_q), 4'h0}))
      else $error("mask read wrong");

   a_clear_reads_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_rd && i_addr == uisc_pkg::OFF_ICR) |=> o_rdata == 32'h0)
      else $error("clear register read not zero");

   a_unmapped_read: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_rd && i_addr != uisc_pkg::OFF_MASK && i_addr != uisc_pkg::OFF_RAW
       && i_addr != uisc_pkg::OFF_MIS && i_addr != uisc_pkg::OFF_ID4
       && i_addr != uisc_pkg::OFF_ID5) |=> o_rdata == 32'h0)
      else $error("unmapped read not zero");

endmodule : uisc_irq_status

// *** bench/uisc_evt_model.sv ***
// Serial engine stand-in: passes bench requests on as event pulses, one cycle later
`timescale 1ns/1ps
module uisc_evt_model (
   // Clock
   input wire logic i_clk,
   // Requested sources, register order from overrun down to receive
   input wire logic [6:0] i_req,
   // Event pulses toward the status slice
   output uisc_pkg::uisc_flags_t o_evt
);
   always_ff @(posedge i_clk) begin
      o_evt <= uisc_pkg::uisc_flags_t'(i_req);
   end
endmodule : uisc_evt_model

// *** bench/uart_interrupt_status_clear_bench.sv ***
// Self-checking bench of the serial port interrupt status slice
`timescale 1ns/1ps
module uart_interrupt_status_clear_bench;
   typedef struct {logic [6:0] evt; logic [31:0] mask; logic [31:0] mis;} uisc_row_t;
   logic i_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic [11:0] i_addr = 12'h000;
   logic [31:0] i_wdata = 32'h0000_0000;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [6:0] evt_req = 7'h00;
   logic [31:0] o_rdata;
   logic o_irq;
   uisc_pkg::uisc_flags_t src_evt;
   uisc_pkg::uisc_flags_t o_masked;
   int fail_count = 0;
   int n_tests = 0;
   uisc_row_t rows [4] = '{'{7'h7f, 32'h7f0, 32'h7f0}, '{7'h40, 32'h400, 32'h400},
      '{7'h01, 32'h400, 32'h000}, '{7'h2a, 32'h0f0, 32'h0a0}};
   initial begin
      forever #20 i_clk = ~i_clk;
   end
   uisc_evt_model partner (.i_clk(i_clk), .i_req(evt_req), .o_evt(src_evt));
   // Identification values are arbitrary
   uisc_irq_status #(.IDENT_LOW(8'h3c), .IDENT_NEXT(8'hc3)) dut (.i_clk(i_clk),
      .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .i_src_evt(src_evt), .o_masked(o_masked), .o_irq(o_irq));
   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      chk(o_rdata, exp);
   endtask : rd
   // Pulse the sources, then wait until the masked outputs have settled
   task automatic fire(input logic [6:0] p);
      @(posedge i_clk);
      evt_req <= p;
      @(posedge i_clk);
      evt_req <= 7'h00;
      repeat (3) @(posedge i_clk);
      #1;
   endtask : fire
   initial begin
      repeat (3000) @(posedge i_clk);
      fail_count++;
      give_verdict();
   end
   initial begin
      repeat (5) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      rd(uisc_pkg::OFF_MIS, 32'h0);
      rd(uisc_pkg::OFF_ICR, 32'h0);
      rd(uisc_pkg::OFF_ID4, 32'h0000_003c);
      rd(uisc_pkg::OFF_ID5, 32'h0000_00c3);
      rd(12'h100, 32'h0);
      foreach (rows[k]) begin
         wr(uisc_pkg::OFF_MASK, rows[k].mask);
         fire(rows[k].evt);
         chk({31'h0, o_irq}, {31'h0, rows[k].mis != 32'h0});
         chk({25'h0, o_masked}, {25'h0, rows[k].mis[10:4]});
         rd(uisc_pkg::OFF_MIS, rows[k].mis);
         wr(uisc_pkg::OFF_ICR, 32'h0000_07f0);
         rd(uisc_pkg::OFF_MIS, 32'h0);
      end
      wr(uisc_pkg::OFF_MASK, 32'h7f0);
      fire(7'h7f);
      wr(uisc_pkg::OFF_MIS, 32'h0);
      wr(uisc_pkg::OFF_ID4, 32'hffff_ffff);
      wr(uisc_pkg::OFF_ID5, 32'h0);
      rd(uisc_pkg::OFF_MIS, 32'h7f0);
      rd(uisc_pkg::OFF_ID4, 32'h0000_003c);
      rd(uisc_pkg::OFF_ID5, 32'h0000_00c3);
      wr(uisc_pkg::OFF_ICR, 32'h0000_0000);
      rd(uisc_pkg::OFF_MIS, 32'h7f0);
      wr(uisc_pkg::OFF_ICR, 32'h0000_0400);
      rd(uisc_pkg::OFF_MIS, 32'h3f0);
      wr(uisc_pkg::OFF_ICR, 32'h0000_0010);
      rd(uisc_pkg::OFF_MIS, 32'h3e0);
      // Second reset in mid-run drops both status and mask
      @(posedge i_clk);
      i_sys_rst <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      rd(uisc_pkg::OFF_RAW, 32'h0000_000f);
      fire(7'h7f);
      chk({31'h0, o_irq}, 32'h0);
      rd(uisc_pkg::OFF_MIS, 32'h0);
      rd(uisc_pkg::OFF_RAW, 32'h0000_07ff);
      wr(uisc_pkg::OFF_ICR, 32'h0000_07f0);
      // Receive event and its clear reach the slice at the same edge
      @(posedge i_clk);
      evt_req <= 7'h01;
      i_addr <= uisc_pkg::OFF_ICR;
      i_wdata <= 32'h0000_0010;
      @(posedge i_clk);
      evt_req <= 7'h00;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
      rd(uisc_pkg::OFF_RAW, 32'h0000_001f);
      give_verdict();
   end
endmodule : uart_interrupt_status_clear_bench
